// ---- abr_rate_pkg.sv ----
// Purpose: shared constants and types for the abr rate control block
// Assumes: rates are linear 16-bit numbers, 1/65536 cell per clock each
// Notes:   register offsets are byte addresses on the ahb-lite bus
package abr_rate_pkg;

   // ************************************************************
   // clock and timing
   // ************************************************************
   localparam longint CLK_HZ          = 250_000_000;  // core_clk rate
   localparam longint TCR_CELLS_PER_S = 10;           // tagged cell rate
   localparam longint TCR_PERIOD_CYC  = CLK_HZ / TCR_CELLS_PER_S;
   localparam longint TRM_MS          = 100;          // trm default, ms
   localparam longint ADTF_MS         = 500;          // adtf default, ms
   localparam logic [31:0] TRM_RST  = 32'(CLK_HZ * TRM_MS / 1000);
   localparam logic [31:0] ADTF_RST = 32'(CLK_HZ * ADTF_MS / 1000);

   // ************************************************************
   // rates and abr parameters
   // ************************************************************
   localparam int          RATE_W     = 16;       // rate width
   localparam int          MRM_CELLS  = 2;        // fixed mrm
   localparam int          UIOL_SHIFT = 4;        // 15/16 = 1 - 1/16
   localparam logic [3:0]  CDF_ZERO   = 4'hf;     // cdf code meaning 0
   localparam logic [15:0] PCR_RST    = 16'hffff;
   localparam logic [15:0] MCR_RST    = 16'h0000;
   localparam logic [15:0] ICR_RST    = 16'h0100;
   localparam logic [3:0]  RIF_RST    = 4'h0;     // rif = 1
   localparam logic [3:0]  RDF_RST    = 4'hf;     // rdf = 1/32768
   localparam logic [3:0]  CDF_RST    = 4'h4;     // cdf = 1/16
   localparam logic [8:0]  NRM_RST    = 9'h020;   // nrm = 32
   localparam logic [7:0]  CRM_RST    = 8'h10;

   // ************************************************************
   // register map (byte offsets) and field positions
   // ************************************************************
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_PCR    = 8'h04;
   localparam logic [7:0] OFS_MCR    = 8'h08;
   localparam logic [7:0] OFS_ICR    = 8'h0c;
   localparam logic [7:0] OFS_FACT   = 8'h10;
   localparam logic [7:0] OFS_COUNT  = 8'h14;
   localparam logic [7:0] OFS_TRM    = 8'h18;
   localparam logic [7:0] OFS_ADTF   = 8'h1c;
   localparam logic [7:0] OFS_ACR    = 8'h20;
   localparam logic [7:0] OFS_STATUS = 8'h24;
   localparam int CTRL_SETUP   = 0;   // write 1: set up connection
   localparam int CTRL_CONG_EN = 1;   // receive congestion command
   localparam int CTRL_CONG_CI = 2;
   localparam int CTRL_CONG_NI = 3;
   localparam int STAT_LCI     = 1;   // write 1 clears

   // ************************************************************
   // cell carriers
   // ************************************************************
   typedef enum logic [1:0] {
      KIND_DATA = 2'b00,
      KIND_FRM  = 2'b01,
      KIND_BRM  = 2'b10
   } cell_kind_t;

   typedef struct packed {
      cell_kind_t          kind;
      logic                clp;
      logic                efci;
      logic                ci;
      logic                ni;
      logic                bn;
      logic [RATE_W-1:0]   er;
      logic [RATE_W-1:0]   ccr;
      logic [RATE_W-1:0]   mcr;
   } cell_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_PACE = 3'b001,
      ST_UIOL = 3'b010,
      ST_CUT  = 3'b011,
      ST_SEND = 3'b100
   } abr_state_t;

endpackage

// ---- abr_rate_control.sv ----
// Purpose: abr source rate control and destination rm turn-around
// Assumes: one connection; cell slots handed out by txValid/txReady
// Notes:   registers on ahb-lite, zero wait states
//
// Design decisions made here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module abr_rate_control
   import abr_rate_pkg::*;
#(
   parameter longint TCR_CYCLES = TCR_PERIOD_CYC  // out-of-rate frm spacing
) (
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              nrst,
   // ahb-lite register slave
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic                   hresp,
   output logic [31:0]            hrdata,
   // transmit cell slot
   output logic                   txValid,
   output cell_t                  txCell,
   input  wire logic              txReady,
   input  wire logic              dataPending,
   output logic                   dataTaken,
   // received cells
   input  wire logic              rxValid,
   input  wire cell_t             rxCell,
   output logic                   rxReady,
   // congestion indications from neighbouring logic
   input  wire logic              lagOver,
   input  wire logic              acrSumOver,
   input  wire logic              actualOver,
   input  wire logic              rxFifoOver,
   input  wire logic              poolEmpty
);

   generate
      if (TCR_CYCLES < 1 || TCR_CYCLES > 64'hffff_ffff) begin : g_bad
         $error("TCR_CYCLES out of range");
      end
   endgenerate

   localparam logic [31:0] TCR_CYC = 32'(TCR_CYCLES);

   // limit a wide value into [lo, hi]; hi wins if the two cross
   function automatic logic [RATE_W-1:0] clampRate(
      input logic [RATE_W:0]   v,
      input logic [RATE_W-1:0] lo,
      input logic [RATE_W-1:0] hi);
      logic [RATE_W:0] t;
      t = v;
      if (t < {1'b0, lo}) t = {1'b0, lo};
      if (t > {1'b0, hi}) t = {1'b0, hi};
      return t[RATE_W-1:0];
   endfunction

   // ************************************************************
   // ahb-lite slave
   // ************************************************************
   logic                addrPhase;   // transfer taken this edge
   logic                wrPend_q;    // write data phase follows
   logic [7:0]          wrAddr_q;    // latched write offset
   logic [31:0]         rdMux;       // read data selection
   logic [31:0]         hrdata_q;
   logic                setupPulse;  // write 1 to setup bit
   logic                lciClear;    // write 1 to status lci
   logic                ctrlWr;

   // control and parameter registers
   logic [3:1]          ctrl_q;
   logic [RATE_W-1:0]   pcr_q, mcr_q, icr_q;
   logic [3:0]          rif_q, rdf_q, cdf_q;
   logic [8:0]          nrm_q;
   logic [7:0]          crm_q;
   logic [31:0]         trm_q, adtf_q;

   // state the block keeps
   abr_state_t          st_q, st_d;
   logic [RATE_W-1:0]   acr_q, acr_d;
   logic                active_q, firstFrm_q, lci_q, uiolBlock_q;
   logic                uiolCut_q, efciState_q;
   logic                brmPend_q, oorPend_q, brmSinceFrm_q;
   cell_t               brmBuf_q, oorCell_q, txCell_q, newBrm;
   logic                txValid_q;
   logic [8:0]          cellCnt_q;
   logic [7:0]          crmCnt_q;
   logic [31:0]         trmTmr_q, adtfTmr_q, tcrTmr_q;
   logic [RATE_W:0]     acc_q;       // pacing accumulator
   logic                credit_q;    // one in-rate slot earned

   assign addrPhase  = hsel & htrans[1] & hready;
   assign hreadyout  = 1'b1;
   assign hresp      = 1'b0;
   assign hrdata     = hrdata_q;
   assign ctrlWr     = wrPend_q & (wrAddr_q == OFS_CTRL);
   assign setupPulse = ctrlWr & hwdata[CTRL_SETUP];
   assign lciClear   = wrPend_q & (wrAddr_q == OFS_STATUS)
                       & hwdata[STAT_LCI];

   // read selection; unmapped offsets read as zero
   assign rdMux =
      (haddr[7:0] == OFS_CTRL)   ? {28'h0, ctrl_q, 1'b0} :
      (haddr[7:0] == OFS_PCR)    ? {16'h0, pcr_q} :
      (haddr[7:0] == OFS_MCR)    ? {16'h0, mcr_q} :
      (haddr[7:0] == OFS_ICR)    ? {16'h0, icr_q} :
      (haddr[7:0] == OFS_FACT)   ? {20'h0, cdf_q, rdf_q, rif_q} :
      (haddr[7:0] == OFS_COUNT)  ? {15'h0, crm_q, nrm_q} :
      (haddr[7:0] == OFS_TRM)    ? trm_q :
      (haddr[7:0] == OFS_ADTF)   ? adtf_q :
      (haddr[7:0] == OFS_ACR)    ? {16'h0, acr_q} :
      (haddr[7:0] == OFS_STATUS) ? {25'h0, brmSinceFrm_q, oorPend_q,
                                    brmPend_q, uiolBlock_q, efciState_q,
                                    lci_q, active_q} :
      32'h0000_0000;

   // address phase latch; read data sampled early so it comes from a flop
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         wrPend_q <= 1'b0;
         wrAddr_q <= 8'h00;
         hrdata_q <= 32'h0000_0000;
      end else begin
         wrPend_q <= addrPhase & hwrite;
         if (addrPhase) begin
            wrAddr_q <= haddr[7:0];
            hrdata_q <= hwrite ? 32'h0000_0000 : rdMux;
         end
      end
   end

   // parameter registers written in the data phase
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         ctrl_q <= 3'h0;
         pcr_q  <= PCR_RST;
         mcr_q  <= MCR_RST;
         icr_q  <= ICR_RST;
         rif_q  <= RIF_RST;
         rdf_q  <= RDF_RST;
         cdf_q  <= CDF_RST;
         nrm_q  <= NRM_RST;
         crm_q  <= CRM_RST;
         trm_q  <= TRM_RST;
         adtf_q <= ADTF_RST;
      end else if (wrPend_q) begin
         case (wrAddr_q)
            OFS_CTRL:  ctrl_q <= hwdata[3:1];
            OFS_PCR:   pcr_q  <= hwdata[RATE_W-1:0];
            OFS_MCR:   mcr_q  <= hwdata[RATE_W-1:0];
            OFS_ICR:   icr_q  <= hwdata[RATE_W-1:0];
            OFS_FACT: begin
               rif_q <= hwdata[3:0];
               rdf_q <= hwdata[7:4];
               cdf_q <= hwdata[11:8];
            end
            OFS_COUNT: begin
               nrm_q <= hwdata[8:0];
               crm_q <= hwdata[16:9];
            end
            OFS_TRM:   trm_q  <= hwdata;
            OFS_ADTF:  adtf_q <= hwdata;
            default: ;  // read-only or unmapped: ignored
         endcase
      end
   end

   // ************************************************************
   // transmit selection
   // ************************************************************
   logic txFree, frmDue, pickBrm, inSlot, adtfIdle;
   logic loadInBrm, loadData, loadFrm, loadOor, rxTake, rxBrm;
   logic [RATE_W-1:0] uiolStep, cdfStep, rxAdj;
   logic [RATE_W:0]   rxWork;

   assign txFree = ~txValid_q | txReady;
   assign frmDue = firstFrm_q
                 | (cellCnt_q >= nrm_q - 9'd1)
                 | ((cellCnt_q >= 9'(MRM_CELLS))
                    & (trmTmr_q >= trm_q));
   assign pickBrm = brmPend_q & (~brmSinceFrm_q | ~dataPending);
   assign inSlot  = (st_q == ST_PACE) & credit_q & txFree;
   assign loadInBrm = inSlot & ~frmDue & pickBrm;
   assign loadData  = inSlot & ~frmDue & ~pickBrm & dataPending;
   assign loadFrm   = (st_q == ST_SEND) & txFree;
   // out-of-rate only takes a slot the in-rate stream leaves unused
   assign loadOor   = oorPend_q & txFree & (st_q == ST_PACE)
                      & ~loadInBrm & ~loadData & ~(credit_q & frmDue);
   assign dataTaken = loadData;
   assign adtfIdle  = active_q & (st_q == ST_PACE)
                      & (adtfTmr_q >= adtf_q)
                      & ~dataPending & ~brmPend_q;

   // receive side accepted unless a pre-send reduction owns acr
   assign rxReady = (st_q != ST_UIOL) & (st_q != ST_CUT);
   assign rxTake  = rxValid & rxReady;
   assign rxBrm   = rxTake & (rxCell.kind == KIND_BRM);

   // ************************************************************
   // rate arithmetic
   // ************************************************************
   assign uiolStep = clampRate({1'b0, acr_q - (acr_q >> UIOL_SHIFT)},
                               mcr_q, pcr_q);
   assign cdfStep  = (cdf_q == CDF_ZERO) ? mcr_q :
                     clampRate({1'b0, acr_q >> cdf_q},
                               mcr_q, pcr_q);

   // backward cell: congestion step, then er limit, floor mcr
   always_comb begin
      rxWork = {1'b0, acr_q};
      if (rxCell.ci) begin
         rxWork = {1'b0, acr_q >> rdf_q};
         if (lci_q) rxWork = rxWork >> 1;
      end else if (~rxCell.ni & ~lci_q & ~uiolBlock_q) begin
         rxWork = {1'b0, acr_q} + {1'b0, pcr_q >> rif_q};
      end
      if (rxWork > {1'b0, rxCell.er}) rxWork = {1'b0, rxCell.er};
      rxAdj = clampRate(rxWork, mcr_q, pcr_q);
   end

   // one writer of acr, highest priority first
   always_comb begin
      acr_d = acr_q;
      if (setupPulse) acr_d = icr_q;
      else if (st_q == ST_UIOL && actualOver && acr_q > mcr_q)
         acr_d = uiolStep;
      else if (st_q == ST_CUT && crmCnt_q >= crm_q && acr_q > mcr_q)
         acr_d = cdfStep;
      else if (adtfIdle) acr_d = (acr_q >= icr_q) ? icr_q : acr_q;
      else if (rxBrm) acr_d = rxAdj;
   end

   // ************************************************************
   // scheduler state machine
   // ************************************************************
   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_IDLE: if (active_q) st_d = ST_PACE;
         ST_PACE: begin
            if (!active_q || adtfIdle) st_d = ST_IDLE;
            else if (credit_q && txFree && frmDue) st_d = ST_UIOL;
         end
         ST_UIOL: if (!(actualOver && acr_q > mcr_q)) st_d = ST_CUT;
         ST_CUT:  st_d = ST_SEND;
         ST_SEND: if (txFree) st_d = ST_PACE;
         default: st_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         st_q  <= ST_IDLE;
         acr_q <= ICR_RST;
      end else begin
         st_q  <= setupPulse ? ST_PACE : st_d;
         acr_q <= acr_d;
      end
   end

   // pacing: a carry of the accumulator earns one in-rate slot
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         acc_q    <= '0;
         credit_q <= 1'b0;
      end else begin
         acc_q <= {1'b0, acc_q[RATE_W-1:0]} + {1'b0, acr_q};
         if (acc_q[RATE_W])
            credit_q <= 1'b1;
         else if (loadInBrm || loadData || loadFrm)
            credit_q <= 1'b0;
      end
   end

   // activity, use-it-or-lose-it and frm bookkeeping
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         active_q      <= 1'b0;
         firstFrm_q    <= 1'b0;
         uiolBlock_q   <= 1'b0;
         uiolCut_q     <= 1'b0;
         cellCnt_q     <= 9'h000;
         crmCnt_q      <= 8'h00;
         brmSinceFrm_q <= 1'b0;
         trmTmr_q      <= 32'h0000_0000;
         adtfTmr_q     <= 32'h0000_0000;
      end else begin
         if (setupPulse) begin
            active_q   <= 1'b1;
            firstFrm_q <= 1'b1;
         end else if (adtfIdle) begin
            active_q <= 1'b0;
         end else if (!active_q && (dataPending || brmPend_q)) begin
            active_q   <= 1'b1;
            firstFrm_q <= 1'b1;
         end else if (loadFrm) begin
            firstFrm_q <= 1'b0;
         end
         if (st_q == ST_PACE && st_d == ST_UIOL) uiolCut_q <= 1'b0;
         else if (st_q == ST_UIOL && acr_d != acr_q) uiolCut_q <= 1'b1;
         // increase stays barred until an frm goes without a cut
         if (loadFrm) uiolBlock_q <= uiolCut_q;
         if (loadFrm) begin
            cellCnt_q     <= 9'h000;
            brmSinceFrm_q <= 1'b0;
            trmTmr_q      <= 32'h0000_0000;
            adtfTmr_q     <= 32'h0000_0000;
         end else begin
            if ((loadInBrm || loadData) && cellCnt_q != 9'h1ff)
               cellCnt_q <= cellCnt_q + 9'd1;
            if (loadInBrm) brmSinceFrm_q <= 1'b1;
            if (trmTmr_q != 32'hffff_ffff) trmTmr_q <= trmTmr_q + 32'd1;
            if (adtfTmr_q != 32'hffff_ffff)
               adtfTmr_q <= adtfTmr_q + 32'd1;
         end
         // own backward cell (bn 0) restarts the missing count
         if (rxBrm && !rxCell.bn) crmCnt_q <= 8'h00;
         else if (loadFrm && crmCnt_q != 8'hff)
            crmCnt_q <= crmCnt_q + 8'd1;
      end
   end

   // internal congestion flag; a new cause beats a software clear
   always_ff @(posedge core_clk) begin
      if (!nrst) lci_q <= 1'b0;
      else if (lagOver || acrSumOver) lci_q <= 1'b1;
      else if (lciClear) lci_q <= 1'b0;
   end

   // ************************************************************
   // destination turn-around
   // ************************************************************
   always_comb begin
      newBrm      = rxCell;
      newBrm.kind = KIND_BRM;
      newBrm.bn   = 1'b0;
      newBrm.clp  = 1'b0;
      newBrm.efci = 1'b0;
      newBrm.ci   = rxCell.ci | efciState_q
                  | (ctrl_q[CTRL_CONG_EN] & ctrl_q[CTRL_CONG_CI])
                  | rxFifoOver | poolEmpty;
      newBrm.ni   = rxCell.ni
                  | (ctrl_q[CTRL_CONG_EN] & ctrl_q[CTRL_CONG_NI]);
   end

   // turn-around buffers, efci state and the out-of-rate slot
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         efciState_q <= 1'b0;
         brmPend_q   <= 1'b0;
         brmBuf_q    <= '0;
         oorPend_q   <= 1'b0;
         oorCell_q   <= '0;
         tcrTmr_q    <= 32'h0000_0000;
      end else begin
         if (rxTake && rxCell.kind == KIND_DATA)
            efciState_q <= rxCell.efci;
         else if (rxTake && rxCell.kind == KIND_FRM)
            efciState_q <= 1'b0;
         // tagged-rate timer runs only while acr is zero
         if (!active_q || acr_q != '0 || tcrTmr_q >= TCR_CYC - 32'd1)
            tcrTmr_q <= 32'h0000_0000;
         else
            tcrTmr_q <= tcrTmr_q + 32'd1;
         if (rxTake && rxCell.kind == KIND_FRM) begin
            brmBuf_q  <= newBrm;
            brmPend_q <= 1'b1;
            if (brmPend_q) begin
               oorCell_q     <= newBrm;
               oorCell_q.clp <= 1'b1;
               oorPend_q     <= 1'b1;
            end else if (loadOor) begin
               oorPend_q <= 1'b0;
            end
         end else begin
            if (loadInBrm) brmPend_q <= 1'b0;
            if (active_q && acr_q == '0 && !oorPend_q
                && tcrTmr_q >= TCR_CYC - 32'd1) begin
               oorCell_q      <= '0;
               oorCell_q.kind <= KIND_FRM;
               oorCell_q.clp  <= 1'b1;
               oorCell_q.er   <= pcr_q;
               oorCell_q.mcr  <= mcr_q;
               oorPend_q      <= 1'b1;
            end else if (loadOor) begin
               oorPend_q <= 1'b0;
            end
         end
      end
   end

   // ************************************************************
   // transmit register
   // ************************************************************
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         txValid_q <= 1'b0;
         txCell_q  <= '0;
      end else begin
         if (loadFrm) begin
            txCell_q      <= '0;
            txCell_q.kind <= KIND_FRM;
            txCell_q.er   <= pcr_q;
            txCell_q.ccr  <= acr_q;
            txCell_q.mcr  <= mcr_q;
         end else if (loadInBrm) begin
            txCell_q     <= brmBuf_q;
            txCell_q.clp <= 1'b0;
         end else if (loadData) begin
            txCell_q      <= '0;
            txCell_q.kind <= KIND_DATA;
            txCell_q.efci <= 1'b0;
         end else if (loadOor) begin
            txCell_q <= oorCell_q;
         end
         if (loadFrm || loadInBrm || loadData || loadOor)
            txValid_q <= 1'b1;
         else if (txReady)
            txValid_q <= 1'b0;
      end
   end

   assign txValid = txValid_q;
   assign txCell  = txCell_q;

endmodule // abr_rate_control

// ---- abr_rate_control_monitor.sv ----
// Purpose: port checker for the abr rate control block
// Assumes: nrst synchronous active low
// Notes:   bound to the design after the module
`timescale 1ns/10ps
module abr_rate_control_monitor
   import abr_rate_pkg::*;
(
   // clock and reset
   input wire logic  core_clk,
   input wire logic  nrst,
   // bus status
   input wire logic  hreadyout,
   input wire logic  hresp,
   // cell slots
   input wire logic  txValid,
   input wire logic  txReady,
   input wire logic  dataPending,
   input wire logic  dataTaken,
   input wire logic  rxReady,
   input wire cell_t txCell
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // a data cell stands on the slot
   wire logic dat = txValid && txCell.kind == KIND_DATA;
   AST_DATA_CLP: assert property (dat |-> !txCell.clp)
      else $error("data cell with clp set");
   AST_DATA_EFCI: assert property (dat |-> !txCell.efci)
      else $error("data cell with efci set");
   AST_OOR_RM: assert property (txValid && txCell.clp |-> !dat)
      else $error("out-of-rate data cell");
   AST_TURN_BN: assert property (txValid && txCell.kind == KIND_BRM
      |-> !txCell.bn)
      else $error("returned cell with bn set");
   AST_TAKE_DATA: assert property (dataTaken |=> dat)
      else $error("taken data cell not offered");
   AST_TAKE_PEND: assert property (dataTaken |-> dataPending)
      else $error("data taken with none waiting");
   // a stalled cell must not change under the consumer
   AST_HOLD: assert property (txValid && !txReady
      |=> txValid && $stable(txCell))
      else $error("cell changed while stalled");
   // nothing is offered while a pre-send cut holds the receive side
   AST_RX_HOLD: assert property (!rxReady |-> !txValid)
      else $error("cell offered during rate cut");
   AST_BUS_OK: assert property (hreadyout && !hresp)
      else $error("bus not ready or error");
   cover property (dataTaken);
   cover property (txValid && txReady && txCell.kind == KIND_BRM);
   cover property (txValid && txReady && txCell.kind == KIND_FRM);
   cover property (!rxReady);
endmodule // abr_rate_control_monitor
bind abr_rate_control abr_rate_control_monitor mon (
   .core_clk(core_clk), .nrst(nrst), .hreadyout(hreadyout),
   .hresp(hresp), .txValid(txValid), .txReady(txReady),
   .dataPending(dataPending), .dataTaken(dataTaken),
   .rxReady(rxReady), .txCell(txCell));

// ---- abr_peer_sink.sv ----
// Purpose: network peer taking transmitted cells
// Assumes: shares the bench random stream
// Notes:   stalls about one slot in four
`timescale 1ns/10ps
module abr_peer_sink (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic nrst,
   // cell slot handshake
   output logic      txReady
);
   // random stalls show that no cell is lost or altered while held
   always_ff @(posedge core_clk) begin
      txReady <= nrst && ($urandom % 4 != 0);
   end
endmodule // abr_peer_sink

// ---- test_abr_rate_control.sv ----
// Purpose: self-checking bench for abr_rate_control
// Assumes: zero wait state slave, nrm set to 4
// Notes:   cells taken are compared against a queue of notes
`timescale 1ns/10ps
module test_abr_rate_control;
   import abr_rate_pkg::*;
   logic core_clk, nrst, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic txValid, txReady, dataPending, dataTaken, rxValid, rxReady;
   logic lagOver, acrSumOver, actualOver, rxFifoOver, poolEmpty;
   cell_t txCell, rxCell, c, m, b, bm, d, dm, f, fm, x;
   cell_t expQ[$], mskQ[$];     // expected cells and compare masks
   int    errors, cmp_count;
   assign hready = hreadyout;
   abr_rate_control #(.TCR_CYCLES(50)) DUT (
      .core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .txValid(txValid), .txCell(txCell),
      .txReady(txReady), .dataPending(dataPending),
      .dataTaken(dataTaken), .rxValid(rxValid), .rxCell(rxCell),
      .rxReady(rxReady), .lagOver(lagOver), .acrSumOver(acrSumOver),
      .actualOver(actualOver), .rxFifoOver(rxFifoOver),
      .poolEmpty(poolEmpty));
   abr_peer_sink peer (.core_clk(core_clk), .nrst(nrst),
                       .txReady(txReady));
   initial begin
      core_clk = 0;
      forever #2 core_clk = ~core_clk;
   end
   task chk(input logic [63:0] s, e);
      cmp_count++;
      if (s !== e) begin
         errors++;
         $display("[FAIL] %0t seen %h exp %h", $time, s, e);
      end
   endtask
   task results;
      $display("compares %0d errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // one single word transfer, read data kept in rd
   task ahb(input logic w, input logic [7:0] a, input logic [31:0] v);
      hsel <= 1; htrans <= 2'b10; hwrite <= w; haddr <= {24'h0, a};
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00; hwdata <= v;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   // one received cell; an extra edge keeps rxValid from being set twice
   task rx(input cell_kind_t k, input logic e, ci, input logic [15:0] er);
      c = cell_t'(55'({$urandom, $urandom}));
      c.kind = k; c.efci = e; c.ci = ci; c.ni = 0; c.er = er;
      rxValid <= 1; rxCell <= c;
      do @(posedge core_clk); while (rxReady !== 1'b1);
      rxValid <= 0;
      @(posedge core_clk);
   endtask
   task ex(input cell_t e, k);
      expQ.push_back(e); mskQ.push_back(k);
   endtask
   // compare each taken cell with the oldest note
   always @(posedge core_clk) begin
      if (txValid && txReady && expQ.size() > 0) begin
         m = mskQ.pop_front();
         x = expQ.pop_front();
         chk(64'(txCell & m), 64'(x & m));
      end
   end
   initial begin
      #80000; errors++; results();
   end
   initial begin
      void'($urandom(32'h995d));
      {nrst, hsel, hwrite, rxValid, dataPending, lagOver} = '0;
      {acrSumOver, actualOver, rxFifoOver, poolEmpty} = '0;
      htrans = 0; hsize = 3'h2; haddr = 0; hwdata = 0; rxCell = '0;
      repeat (3) @(posedge core_clk);
      nrst <= 1;
      @(posedge core_clk);
      ahb(0, OFS_ACR, 0); chk(rd, 32'h0100);
      ahb(0, 8'h3c, 0); chk(rd, 0);
      ahb(1, OFS_COUNT, 32'h0000_2004);
      ahb(1, OFS_CTRL, 1);
      rx(KIND_DATA, 1, 0, 16'h0);
      ahb(0, OFS_STATUS, 0); chk(rd & 4, 4);
      rx(KIND_FRM, 0, 0, 16'($urandom));
      d = '0; d.kind = KIND_DATA; dm = '0; dm.clp = 1; dm.efci = 1;
      dm.kind = cell_kind_t'(2'b11);
      f = d; f.kind = KIND_FRM; f.ccr = 16'h0100; fm = dm; fm.efci = 0;
      fm.ccr = '1; b = c; b.kind = KIND_BRM; b.bn = 0; b.ci = 1;
      b.clp = 0; bm = '1; bm.efci = 0;
      ex(f, fm); ex(b, bm); ex(d, dm); ex(d, dm); ex(f, fm);
      dataPending <= 1;
      repeat (4000) if (expQ.size() != 0) @(posedge core_clk);
      chk(expQ.size(), 0);
      dataPending <= 0;
      ahb(0, OFS_STATUS, 0); chk(rd & 4, 0);
      rx(KIND_BRM, 0, 0, 16'h0200);
      ahb(0, OFS_ACR, 0); chk(rd, 32'h0200);
      ahb(1, OFS_MCR, 32'h0300);
      rx(KIND_BRM, 0, 1, 16'hffff);
      ahb(0, OFS_ACR, 0); chk(rd, 32'h0300);
      lagOver <= 1;
      @(posedge core_clk);
      lagOver <= 0;
      ahb(0, OFS_STATUS, 0);
      chk(rd & 2, 2);
      ahb(1, OFS_STATUS, 2);
      ahb(0, OFS_STATUS, 0);
      chk(rd & 2, 0);
      // let any owed frm go first, so the turned cell is the next one
      repeat (600) @(posedge core_clk);
      ahb(1, OFS_CTRL, 32'h0000_000a);
      d = '0;
      d.kind = KIND_BRM;
      d.ni = 1;
      dm = '0;
      dm.kind = cell_kind_t'(2'b11);
      dm.ni = 1;
      ex(d, dm);
      rx(KIND_FRM, 0, 0, 16'($urandom));
      repeat (4000) if (expQ.size() != 0) @(posedge core_clk);
      chk(expQ.size(), 0);
      results();
   end
endmodule // test_abr_rate_control
